// *** rtl/srbc_pkg.sv ***
// shared constants, types and register map for the string, repeat and branch control block
package srbc_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_SRCI = 8'h08;
    localparam logic [7:0] A_DSTI = 8'h0c;
    localparam logic [7:0] A_CNT = 8'h10;
    localparam logic [7:0] A_ACC = 8'h14;
    localparam logic [7:0] A_FLAG = 8'h18;
    localparam logic [7:0] A_CSEG = 8'h1c;
    localparam logic [7:0] A_IPTR = 8'h20;
    localparam logic [7:0] A_DSEG = 8'h24;
    localparam logic [7:0] A_ESEG = 8'h28;
    localparam logic [7:0] A_TGT = 8'h2c;
    localparam logic [7:0] A_QUE = 8'h30;

    localparam logic [3:0] OP_MOVE = 4'h1;
    localparam logic [3:0] OP_CMP = 4'h2;
    localparam logic [3:0] OP_SCAN = 4'h3;
    localparam logic [3:0] OP_LOAD = 4'h4;
    localparam logic [3:0] OP_STORE = 4'h5;
    localparam logic [3:0] OP_JMP_NEAR = 4'h8;
    localparam logic [3:0] OP_JMP_FAR = 4'h9;
    localparam logic [3:0] OP_JCC = 4'ha;

    localparam logic [1:0] REP_NONE = 2'h0;
    localparam logic [1:0] REP_EQ = 2'h1;
    localparam logic [1:0] REP_NE = 2'h2;

    localparam int CF_BIT = 0;
    localparam int PF_BIT = 2;
    localparam int ZF_BIT = 6;
    localparam int SF_BIT = 7;
    localparam int DF_BIT = 10;
    localparam int OF_BIT = 11;

    localparam logic [15:0] RST_REG = 16'h0000;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam int QPTR_W = 3;
    localparam logic [QPTR_W:0] QUEUE_DEPTH = 4'h8;

    // command word layout: op [3:0], word [4], rep [6:5], cond [11:7], disp [23:16]
    typedef struct packed {
        logic [7:0] disp;
        logic [3:0] pad;
        logic [4:0] cond;
        logic [1:0] rep;
        logic word;
        logic [3:0] op;
    } srbc_cmd_t;

    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [19:0] addr;
        logic [15:0] wdata;
    } srbc_mem_t;

    typedef enum logic [2:0] {S_IDLE, S_SRC, S_DST, S_WR, S_JFETCH} srbc_state_t;
endpackage

// *** rtl/srbc_queue_ram.sv ***
// byte storage of the instruction prefetch queue, registered read port
`timescale 1ns/10ps
module srbc_queue_ram
    import srbc_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [QPTR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [QPTR_W-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<QPTR_W)-1];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// *** rtl/srbc_top.sv ***
// string repeat, index stepping, program transfer and prefetch queue control
// Operation
// [RULE_01] source index addresses source, destination index destination
// [RULE_02] repeat prefix decrements count by one
// [RULE_03] zero count at start skips operation
// [RULE_04] software loads count before repeated operation
// [RULE_05] direction flag clear increments, set decrements
// [RULE_06] step one for bytes, two for words
// [RULE_07] fetch address from code segment and pointer
// [RULE_08] prefetch instructions into the queue
// [RULE_09] transfer flushes queue, hands first byte, refills
// [RULE_10] unconditional jump always redirects, near or far
// [RULE_11] eighteen conditions, jump when true else continue
// [RULE_12] signed byte displacement from next instruction
// [RULE_13] compare and scan also stop on zero flag
// [RULE_14] accumulator is scan value, load target, store source
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/10ps
module srbc_top
    import srbc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic MEM_WORD,
    output logic [19:0] MEM_ADDR,
    output logic [15:0] MEM_WDATA,
    input wire logic MEM_ACK,
    input wire logic [15:0] MEM_RDATA,
    output logic [7:0] EXEC_BYTE,
    output logic EXEC_VALID
);
    logic [15:0] si_ff, di_ff, cnt_ff, acc_ff, flags_ff, cs_ff, ip_ff, ds_ff, es_ff, fip_ff, tmp_ff;
    logic [31:0] tgt_ff;
    srbc_cmd_t cmd_ff;
    logic pend_ff;
    srbc_state_t state_ff;
    srbc_mem_t mem_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic [7:0] exec_byte_ff;
    logic exec_valid_ff;
    logic [QPTR_W-1:0] q_wp_ff, q_rp_ff;
    logic [QPTR_W:0] q_cnt_ff;
    logic [7:0] q_rdata;

    logic busy, apb_acc, apb_done, ack, start, is_str, skip, jcc_ok, take_jump;
    logic uses_src, uses_dst, eq, zf_now, elem_done, zf_ok, more, q_push, q_pop, apb_err;
    logic [15:0] jmp_ip, jmp_cs, step, si_step, di_step, nxt_cnt, cmp_a;

    function automatic logic [19:0] seg_addr(input logic [15:0] seg, input logic [15:0] off);
        seg_addr = {seg, 4'h0} + {4'h0, off};
    endfunction

    // one entry per condition code; aliases have codes of their own (02 and 04 both test cf, 01 and 0a both test !cf)
    function automatic logic cond_true(input logic [4:0] c, input logic [15:0] f);
        logic cf, pf, zf, sf, of;
        cf = f[CF_BIT];
        pf = f[PF_BIT];
        zf = f[ZF_BIT];
        sf = f[SF_BIT];
        of = f[OF_BIT];
        case (c)
            5'h00: cond_true = !cf && !zf;
            5'h01: cond_true = !cf;
            5'h02: cond_true = cf;
            5'h03: cond_true = cf || zf;
            5'h04: cond_true = cf;
            5'h05: cond_true = zf;
            5'h06: cond_true = !zf && (sf == of);
            5'h07: cond_true = sf == of;
            5'h08: cond_true = sf != of;
            5'h09: cond_true = zf || (sf != of);
            5'h0a: cond_true = !cf;
            5'h0b: cond_true = !zf;
            5'h0c: cond_true = !of;
            5'h0d: cond_true = !pf;
            5'h0e: cond_true = !sf;
            5'h0f: cond_true = of;
            5'h10: cond_true = pf;
            5'h11: cond_true = sf;
            default: cond_true = 1'b0;
        endcase
    endfunction

    // first memory access of one string element
    function automatic srbc_mem_t first_req(input logic [15:0] s, input logic [15:0] d);
        first_req.req = 1'b1;
        first_req.word = cmd_ff.word;
        first_req.we = cmd_ff.op == OP_STORE;
        first_req.wdata = acc_ff; // [RULE_14]
        first_req.addr = (cmd_ff.op == OP_SCAN || cmd_ff.op == OP_STORE) ? seg_addr(es_ff, d)
            : seg_addr(ds_ff, s); // [RULE_01]
    endfunction

    function automatic srbc_state_t first_st();
        case (cmd_ff.op)
            OP_SCAN: first_st = S_DST;
            OP_STORE: first_st = S_WR;
            default: first_st = S_SRC;
        endcase
    endfunction

    assign busy = state_ff != S_IDLE || pend_ff;
    assign apb_acc = PSEL && PENABLE && !pready_ff;
    assign apb_done = PSEL && PENABLE && pready_ff;
    assign ack = mem_ff.req && MEM_ACK;
    assign start = state_ff == S_IDLE && pend_ff && !mem_ff.req;
    assign is_str = cmd_ff.op >= OP_MOVE && cmd_ff.op <= OP_STORE;
    assign skip = cmd_ff.rep != REP_NONE && cnt_ff == RST_REG; // [RULE_03]
    assign jcc_ok = cond_true(cmd_ff.cond, flags_ff); // [RULE_11]
    assign take_jump = start && (cmd_ff.op == OP_JMP_NEAR || cmd_ff.op == OP_JMP_FAR
        || (cmd_ff.op == OP_JCC && jcc_ok)); // [RULE_10]
    assign jmp_ip = (cmd_ff.op == OP_JCC) ? ip_ff + {{8{cmd_ff.disp[7]}}, cmd_ff.disp}
        : tgt_ff[15:0]; // [RULE_12]
    assign jmp_cs = (cmd_ff.op == OP_JMP_FAR) ? tgt_ff[31:16] : cs_ff;
    assign step = cmd_ff.word ? STEP_WORD : STEP_BYTE; // [RULE_06]
    assign uses_src = cmd_ff.op == OP_MOVE || cmd_ff.op == OP_CMP || cmd_ff.op == OP_LOAD;
    assign uses_dst = cmd_ff.op != OP_LOAD;
    assign si_step = !uses_src ? si_ff : flags_ff[DF_BIT] ? si_ff - step : si_ff + step; // [RULE_05]
    assign di_step = !uses_dst ? di_ff : flags_ff[DF_BIT] ? di_ff - step : di_ff + step; // [RULE_05]
    assign cmp_a = (cmd_ff.op == OP_CMP) ? tmp_ff : acc_ff; // [RULE_14]
    assign eq = cmd_ff.word ? cmp_a == MEM_RDATA : cmp_a[7:0] == MEM_RDATA[7:0];
    assign zf_now = (state_ff == S_DST) ? eq : flags_ff[ZF_BIT];
    assign elem_done = ack && (state_ff == S_WR || state_ff == S_DST
        || (state_ff == S_SRC && cmd_ff.op == OP_LOAD));
    assign nxt_cnt = cnt_ff - STEP_BYTE;
    assign zf_ok = !(cmd_ff.op == OP_CMP || cmd_ff.op == OP_SCAN)
        || (cmd_ff.rep == REP_EQ ? zf_now : !zf_now); // [RULE_13]
    assign more = cmd_ff.rep != REP_NONE && nxt_cnt != RST_REG && zf_ok;
    assign q_push = ack && state_ff == S_IDLE;
    assign q_pop = apb_done && !PWRITE && PADDR == A_QUE && !pslverr_ff;
    // every write is refused while a command is queued or running
    assign apb_err = (PWRITE && (busy || PADDR == A_STAT || PADDR == A_QUE))
        || (!PWRITE && PADDR == A_QUE && q_cnt_ff == '0)
        || PADDR > A_QUE || PADDR[1:0] != 2'h0;

    // execution state, architectural registers and memory port
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            si_ff <= RST_REG;
            di_ff <= RST_REG;
            cnt_ff <= RST_REG;
            acc_ff <= RST_REG;
            flags_ff <= RST_REG;
            cs_ff <= RST_REG;
            ip_ff <= RST_REG;
            ds_ff <= RST_REG;
            es_ff <= RST_REG;
            fip_ff <= RST_REG;
            tmp_ff <= RST_REG;
            tgt_ff <= '0;
            cmd_ff <= '0;
            pend_ff <= 1'b0;
            state_ff <= S_IDLE;
            mem_ff <= '0;
            exec_byte_ff <= 8'h00;
            exec_valid_ff <= 1'b0;
        end
        else
        begin
            exec_valid_ff <= 1'b0;
            if (apb_done && PWRITE && !pslverr_ff)
            begin
                case (PADDR)
                    A_CTRL:
                    begin
                        cmd_ff <= PWDATA[23:0];
                        pend_ff <= 1'b1;
                    end
                    A_SRCI: si_ff <= PWDATA[15:0];
                    A_DSTI: di_ff <= PWDATA[15:0];
                    A_CNT: cnt_ff <= PWDATA[15:0]; // [RULE_04]
                    A_ACC: acc_ff <= PWDATA[15:0];
                    A_FLAG: flags_ff <= PWDATA[15:0];
                    A_CSEG: cs_ff <= PWDATA[15:0];
                    A_IPTR:
                    begin
                        ip_ff <= PWDATA[15:0];
                        fip_ff <= PWDATA[15:0];
                    end
                    A_DSEG: ds_ff <= PWDATA[15:0];
                    A_ESEG: es_ff <= PWDATA[15:0];
                    A_TGT: tgt_ff <= PWDATA;
                    default: ;
                endcase
            end
            case (state_ff)
                S_IDLE:
                begin
                    if (q_push)
                    begin
                        mem_ff.req <= 1'b0;
                        // a pointer write in the same cycle wins over the fetch step
                        if (!(apb_done && PWRITE && !pslverr_ff && PADDR == A_IPTR))
                        begin
                            fip_ff <= fip_ff + STEP_BYTE;
                        end
                    end
                    else if (start)
                    begin
                        pend_ff <= 1'b0;
                        if (is_str && !skip) // [RULE_03]
                        begin
                            mem_ff <= first_req(si_ff, di_ff);
                            state_ff <= first_st();
                        end
                        else if (take_jump) // [RULE_09]
                        begin
                            ip_ff <= jmp_ip;
                            cs_ff <= jmp_cs;
                            fip_ff <= jmp_ip;
                            mem_ff <= '{1'b1, 1'b0, 1'b0, seg_addr(jmp_cs, jmp_ip), RST_REG};
                            state_ff <= S_JFETCH;
                        end
                    end
                    else if (!mem_ff.req && !pend_ff && q_cnt_ff != QUEUE_DEPTH) // [RULE_08]
                    begin
                        mem_ff <= '{1'b1, 1'b0, 1'b0, seg_addr(cs_ff, fip_ff), RST_REG}; // [RULE_07]
                    end
                end
                S_SRC:
                begin
                    if (ack)
                    begin
                        tmp_ff <= MEM_RDATA;
                        if (cmd_ff.op == OP_MOVE)
                        begin
                            mem_ff <= '{1'b1, 1'b1, cmd_ff.word, seg_addr(es_ff, di_ff), MEM_RDATA};
                            state_ff <= S_WR;
                        end
                        else if (cmd_ff.op == OP_CMP)
                        begin
                            mem_ff <= '{1'b1, 1'b0, cmd_ff.word, seg_addr(es_ff, di_ff), RST_REG}; // [RULE_01]
                            state_ff <= S_DST;
                        end
                        else
                        begin
                            acc_ff <= cmd_ff.word ? MEM_RDATA : {acc_ff[15:8], MEM_RDATA[7:0]}; // [RULE_14]
                        end
                    end
                end
                S_DST:
                begin
                    if (ack)
                    begin
                        flags_ff[ZF_BIT] <= eq;
                    end
                end
                S_WR: ;
                S_JFETCH:
                begin
                    // first byte at the new location bypasses the queue
                    if (ack) // [RULE_09]
                    begin
                        exec_byte_ff <= MEM_RDATA[7:0];
                        exec_valid_ff <= 1'b1;
                        fip_ff <= fip_ff + STEP_BYTE;
                        mem_ff.req <= 1'b0;
                        state_ff <= S_IDLE;
                    end
                end
                default: state_ff <= S_IDLE;
            endcase
            if (elem_done)
            begin
                si_ff <= si_step;
                di_ff <= di_step;
                if (cmd_ff.rep != REP_NONE)
                begin
                    cnt_ff <= nxt_cnt; // [RULE_02]
                end
                if (more)
                begin
                    mem_ff <= first_req(si_step, di_step);
                    state_ff <= first_st();
                end
                else
                begin
                    mem_ff.req <= 1'b0;
                    state_ff <= S_IDLE;
                end
            end
        end
    end

    // prefetch queue pointers; a taken transfer empties it at once
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            q_wp_ff <= '0;
            q_rp_ff <= '0;
            q_cnt_ff <= '0;
        end
        else if (take_jump) // [RULE_09]
        begin
            q_wp_ff <= '0;
            q_rp_ff <= '0;
            q_cnt_ff <= '0;
        end
        else
        begin
            if (q_push)
            begin
                q_wp_ff <= q_wp_ff + 1'b1;
            end
            if (q_pop)
            begin
                q_rp_ff <= q_rp_ff + 1'b1;
            end
            if (q_push && !q_pop)
            begin
                q_cnt_ff <= q_cnt_ff + 1'b1;
            end
            else if (q_pop && !q_push)
            begin
                q_cnt_ff <= q_cnt_ff - 1'b1;
            end
        end
    end

    srbc_queue_ram u_queue (
        .clk(CLOCK),
        .we(q_push),
        .waddr(q_wp_ff),
        .wdata(MEM_RDATA[7:0]),
        .raddr(q_rp_ff),
        .rdata(q_rdata)
    );

    // apb slave: one wait state, answer registered
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end
        else
        begin
            pready_ff <= apb_acc;
            if (apb_acc)
            begin
                pslverr_ff <= apb_err;
                case (PADDR)
                    A_CTRL: prdata_ff <= {8'h00, cmd_ff};
                    A_STAT: prdata_ff <= {27'h0, q_cnt_ff, busy};
                    A_SRCI: prdata_ff <= {16'h0, si_ff};
                    A_DSTI: prdata_ff <= {16'h0, di_ff};
                    A_CNT: prdata_ff <= {16'h0, cnt_ff};
                    A_ACC: prdata_ff <= {16'h0, acc_ff};
                    A_FLAG: prdata_ff <= {16'h0, flags_ff};
                    A_CSEG: prdata_ff <= {16'h0, cs_ff};
                    A_IPTR: prdata_ff <= {16'h0, ip_ff};
                    A_DSEG: prdata_ff <= {16'h0, ds_ff};
                    A_ESEG: prdata_ff <= {16'h0, es_ff};
                    A_TGT: prdata_ff <= tgt_ff;
                    A_QUE: prdata_ff <= {24'h0, q_rdata};
                    default: prdata_ff <= '0;
                endcase
            end
        end
    end

    assign PRDATA = prdata_ff;
    assign PREADY = pready_ff;
    assign PSLVERR = pslverr_ff;
    assign MEM_REQ = mem_ff.req;
    assign MEM_WE = mem_ff.we;
    assign MEM_WORD = mem_ff.word;
    assign MEM_ADDR = mem_ff.addr;
    assign MEM_WDATA = mem_ff.wdata;
    assign EXEC_BYTE = exec_byte_ff;
    assign EXEC_VALID = exec_valid_ff;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    a_src_offset: assert property ( // [RULE_01]
        state_ff == S_SRC && mem_ff.req |-> mem_ff.addr == seg_addr(ds_ff, si_ff))
        else $error("source access not at data segment plus source index");
    a_count_step: assert property ( // [RULE_02]
        elem_done && cmd_ff.rep != REP_NONE |=> cnt_ff == $past(cnt_ff) - STEP_BYTE)
        else $error("count not reduced by one after repetition");
    a_zero_skip: assert property ( // [RULE_03]
        start && is_str && skip |=> state_ff == S_IDLE && !mem_ff.req && si_ff == $past(si_ff))
        else $error("repeated operation ran with zero count");
    a_dir_down: assert property ( // [RULE_05]
        elem_done && uses_dst && flags_ff[DF_BIT] && !cmd_ff.word |=> di_ff == $past(di_ff) - STEP_BYTE)
        else $error("destination index not decremented by one");
    a_word_up: assert property ( // [RULE_06]
        elem_done && uses_src && !flags_ff[DF_BIT] && cmd_ff.word |=> si_ff == $past(si_ff) + STEP_WORD)
        else $error("source index not incremented by two for word");
    a_fetch_addr: assert property ( // [RULE_07]
        state_ff == S_IDLE && $past(state_ff) == S_IDLE && mem_ff.req && !$past(mem_ff.req)
        |-> !mem_ff.we && mem_ff.addr == seg_addr($past(cs_ff), $past(fip_ff)))
        else $error("fetch address not code segment plus pointer");
    a_prefetch_go: assert property ( // [RULE_08]
        state_ff == S_IDLE && !mem_ff.req && !pend_ff && q_cnt_ff != QUEUE_DEPTH |=> mem_ff.req)
        else $error("prefetch not started with room in queue");
    a_flush_fetch: assert property ( // [RULE_09]
        take_jump |=> q_cnt_ff == '0 && state_ff == S_JFETCH && mem_ff.addr == seg_addr(cs_ff, ip_ff))
        else $error("transfer did not flush queue and fetch new target");
    a_far_target: assert property ( // [RULE_10]
        start && cmd_ff.op == OP_JMP_FAR |=> cs_ff == $past(tgt_ff[31:16]) && ip_ff == $past(tgt_ff[15:0]))
        else $error("far jump did not load segment and pointer");
    a_jcc_false: assert property ( // [RULE_11]
        start && cmd_ff.op == OP_JCC && !jcc_ok |=> ip_ff == $past(ip_ff) && state_ff == S_IDLE)
        else $error("untaken conditional jump moved the pointer");
    a_jcc_disp: assert property ( // [RULE_12]
        start && cmd_ff.op == OP_JCC && jcc_ok |=> ip_ff == $past(ip_ff) + {{8{cmd_ff.disp[7]}}, cmd_ff.disp})
        else $error("conditional jump target not pointer plus displacement");
    a_zf_stop: assert property ( // [RULE_13]
        elem_done && cmd_ff.op == OP_SCAN && cmd_ff.rep == REP_NE && eq |=> state_ff == S_IDLE && !mem_ff.req)
        else $error("scan with not-equal repeat did not stop on match");
    a_load_low: assert property ( // [RULE_14]
        ack && state_ff == S_SRC && cmd_ff.op == OP_LOAD && !cmd_ff.word
        |=> acc_ff[15:8] == $past(acc_ff[15:8]) && acc_ff[7:0] == $past(MEM_RDATA[7:0]))
        else $error("byte load did not fill only the accumulator low byte");
endmodule

// *** verif/srbc_mem_model.sv ***
// behavioural memory answering fetch and string accesses
`timescale 1ns/10ps
module srbc_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic req,
    input wire logic we,
    input wire logic word,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    output logic ack,
    output logic [15:0] rdata
);
    logic [7:0] m [int];
    int w;
    function automatic logic [7:0] b(input logic [19:0] a);
        return m.exists(a) ? m[a] : a[7:0] ^ 8'h5a;
    endfunction
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ack <= 1'b0;
            rdata <= 16'h0000;
            w = 0;
        end
        else
        begin
            ack <= 1'b0;
            // outside the ack cycle the data is stale, so keep it moving
            rdata <= ~rdata;
            if (req && !ack && w > 0)
                w = w - 1;
            else if (req && !ack)
            begin
                ack <= 1'b1;
                rdata <= {b(addr + 20'h1), b(addr)};
                if (we)
                    m[addr] = wdata[7:0];
                if (we && word)
                    m[addr + 20'h1] = wdata[15:8];
                w = slow ? $urandom_range(2) : 0;
            end
        end
    end
endmodule

// *** verif/srbc_bench.sv ***
// self-checking bench: string, repeat and transfer commands over the register bus
`timescale 1ns/10ps
module string_repeat_and_branch_control_bench;
    import srbc_pkg::*;
    logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0, chk = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA;
    logic PREADY, PSLVERR, MEM_REQ, MEM_WE, MEM_WORD, MEM_ACK, EXEC_VALID;
    logic [19:0] MEM_ADDR;
    logic [15:0] MEM_WDATA, MEM_RDATA;
    logic [7:0] EXEC_BYTE;
    logic [32:0] rd_q[$];
    logic [7:0] ex_q[$];
    int miscompares = 0, compares = 0;
    always #25 CLOCK = ~CLOCK;
    srbc_top dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE),
        .MEM_WORD(MEM_WORD), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK),
        .MEM_RDATA(MEM_RDATA), .EXEC_BYTE(EXEC_BYTE), .EXEC_VALID(EXEC_VALID));
    srbc_mem_model mem (.clk(CLOCK), .rst(RST), .slow(slow), .req(MEM_REQ), .we(MEM_WE), .word(MEM_WORD),
        .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
    task automatic cmp(input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLOCK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            miscompares++;
            test_done();
        end
        q = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        chk <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [31:0] q;
        rd_q.push_back(e);
        chk <= 1'b1;
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic cmd(input logic [3:0] op, input logic w, input logic [1:0] rp, input logic [4:0] c,
        input logic [7:0] d);
        srbc_cmd_t k;
        logic [31:0] q;
        int n = 0;
        k = '{d, 4'h0, c, rp, w, op};
        wr(A_CTRL, {8'h00, k});
        // busy may stay up for many fetches when the memory stalls
        do
        begin
            apb(1'b0, A_STAT, 32'h0, q);
            n++;
        end
        while (q[0] !== 1'b0 && n < 200);
        if (n >= 200)
        begin
            miscompares++;
            test_done();
        end
    endtask
    function automatic bit jcc_true(input logic [4:0] c, input logic [31:0] f);
        logic cf = f[0], pf = f[2], zf = f[6], sf = f[7], of = f[11];
        logic [17:0] v;
        v = {sf, pf, of, !sf, !pf, !of, !zf, !cf, zf | (sf != of), sf != of, sf == of, !zf & (sf == of),
            zf, cf, cf | zf, cf, !cf, !cf & !zf};
        return v[c];
    endfunction
    always @(posedge CLOCK)
    begin
        if (chk && PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
            cmp(rd_q.pop_front(), {PSLVERR, PRDATA});
        if (EXEC_VALID === 1'b1)
            cmp({25'h0, ex_q.pop_front()}, {25'h0, EXEC_BYTE});
    end
    initial
    begin
        logic [15:0] acc, di, n, st, ip;
        logic [31:0] f;
        logic [19:0] pa;
        logic [7:0] d;
        f = $urandom(11);
        repeat (20) @(posedge CLOCK);
        RST <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            acc = 16'($urandom);
            di = 16'h0200;
            n = 16'($urandom_range(1, 4));
            st = i[1] ? 16'h2 : 16'h1;
            wr(A_ESEG, 32'h1000);
            wr(A_DSEG, 32'h1000);
            wr(A_FLAG, {21'h0, i[0], 10'h0});
            wr(A_ACC, {16'h0, acc});
            wr(A_DSTI, {16'h0, di});
            wr(A_CNT, {16'h0, n});
            cmd(OP_STORE, i[1], REP_EQ, 5'h0, 8'h00);
            rd(A_CNT, 33'h0);
            rd(A_DSTI, {17'h0, i[0] ? di - n * st : di + n * st});
            wr(A_SRCI, {16'h0, di});
            wr(A_ACC, {16'h0, ~acc});
            cmd(OP_LOAD, i[1], REP_NONE, 5'h0, 8'h00);
            rd(A_ACC, {17'h0, i[1] ? acc : {~acc[15:8], acc[7:0]}});
            rd(A_SRCI, {17'h0, i[0] ? di - st : di + st});
        end
        $display("test store_load done");
        wr(A_FLAG, 32'h0);
        wr(A_DSTI, 32'h0300);
        cmd(OP_STORE, 1'b1, REP_NE, 5'h0, 8'h00);
        rd(A_DSTI, 33'h0300);
        wr(A_ACC, 32'h0058);
        wr(A_DSTI, 32'h0400);
        wr(A_CNT, 32'd10);
        cmd(OP_SCAN, 1'b0, REP_NE, 5'h0, 8'h00);
        rd(A_CNT, 33'd7);
        rd(A_FLAG, 33'h0040);
        wr(A_SRCI, 32'h0500);
        wr(A_DSTI, 32'h0601);
        wr(A_CNT, 32'd5);
        cmd(OP_CMP, 1'b0, REP_EQ, 5'h0, 8'h00);
        rd(A_CNT, 33'd4);
        rd(8'h34, {1'b1, 32'h0});
        $display("test skip_scan_compare done");
        ip = 16'($urandom);
        pa = {16'h2000, 4'h0} + 20'(ip);
        ex_q.push_back(pa[7:0] ^ 8'h5a);
        wr(A_TGT, {16'h2000, ip});
        cmd(OP_JMP_FAR, 1'b0, REP_NONE, 5'h0, 8'h00);
        rd(A_CSEG, 33'h2000);
        ip = ip + 16'h0123;
        pa = {16'h2000, 4'h0} + 20'(ip);
        ex_q.push_back(pa[7:0] ^ 8'h5a);
        wr(A_TGT, {16'h0, ip});
        cmd(OP_JMP_NEAR, 1'b0, REP_NONE, 5'h0, 8'h00);
        rd(A_IPTR, {17'h0, ip});
        for (int c = 0; c < 18; c++)
        begin
            f = $urandom & 32'h08c5;
            d = (c == 5) ? 8'h00 : 8'($urandom);
            wr(A_FLAG, f);
            wr(A_IPTR, {16'h0, ip});
            if (jcc_true(5'(c), f))
            begin
                ip = ip + {{8{d[7]}}, d};
                pa = {16'h2000, 4'h0} + 20'(ip);
                ex_q.push_back(pa[7:0] ^ 8'h5a);
            end
            cmd(OP_JCC, 1'b0, REP_NONE, 5'(c), d);
            rd(A_IPTR, {17'h0, ip});
        end
        $display("test transfers done");
        repeat (10) @(posedge CLOCK);
        cmp(33'h0, 33'(ex_q.size()));
        test_done();
    end
endmodule
